// ---- dv/led_safety_timer_battery_guard_tb.sv ----
// testbench: registers, safety timer, battery floor and interrupts
`timescale 1ns/1ps
module led_safety_timer_battery_guard_tb;
    // ************************************************************
    // signals
    // ************************************************************
    localparam int STEP = 4 * lstbg_pkg::TICK_CYCLES;  // cycles per time-out step
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, got;
    logic        waitreq, flash, torch, lowbat, irq;
    logic [12:0] supply = 13'he10;   // 3600 mv, above the reset floor of 3000 mv
    logic [10:0] level = 11'h096;    // 150 ma while lit
    logic [10:0] led_ma;
    logic [3:0]  codes[4] = '{4'h0, 4'h1, 4'h5, 4'h9};
    int          miscompares = 0;
    int          checked = 0;
    int          cnt;

    initial forever #2.5 clk_i = ~clk_i;

    lstbg_top #(.STEP_TICKS(4)) dut (.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
        .avs_waitrequest_o(waitreq), .supply_mv_i(supply), .led_ma_i(led_ma),
        .flash_drive_o(flash), .torch_drive_o(torch), .low_battery_o(lowbat), .irq_o(irq));
    lstbg_led_model u_led (.flash_i(flash), .torch_i(torch), .level_i(level), .led_ma_o(led_ma));

    // verdict and end of run
    task end_sim;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            $display("BAD %s expected %h seen %h", name, exp, seen);
            miscompares++;
        end
    endtask : chk

    // one avalon access; held until waitrequest is sampled low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        addr  <= a;
        wdata <= d;
        wr    <= w;
        rd    <= !w;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (waitreq !== 1'b0 && n < 20);
        got = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        if (waitreq !== 1'b0)
        begin
            miscompares++;
            end_sim();
        end
    endtask : bus

    task rdchk(input logic [3:0] a, input logic [31:0] exp, input string name);
        bus(1'b0, a, 32'h0);
        chk(name, got, exp);
    endtask : rdchk

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        rdchk(lstbg_pkg::ADDR_TIMEOUT, 32'h7, "timeout_rst");
        rdchk(lstbg_pkg::ADDR_FLOOR, 32'h1, "floor_rst");
        rdchk(lstbg_pkg::ADDR_ARMING, 32'h4, "arming_rst");
        rdchk(lstbg_pkg::ADDR_IRQ_MASK, 32'h0, "mask_rst");
        bus(1'b1, 4'hf, 32'h5);
        rdchk(4'hf, 32'h0, "unmapped");
        $display("test registers done");
        // timer trips after (code+1) steps and stays off
        bus(1'b1, lstbg_pkg::ADDR_IRQ_MASK, 32'h1);
        bus(1'b1, lstbg_pkg::ADDR_ARMING, 32'h1);
        for (int n = 0; n < 3; n += 2)
        begin
            bus(1'b1, lstbg_pkg::ADDR_TIMEOUT, 32'(n));
            rdchk(lstbg_pkg::ADDR_TIMEOUT, 32'(n), "timeout_code");
            bus(1'b1, lstbg_pkg::ADDR_CONTROL, n ? 32'h2 : 32'h1);
            repeat (4) @(posedge clk_i);
            rdchk(lstbg_pkg::ADDR_CONTROL, n ? 32'h6 : 32'h5, "ctl_armed");
            for (cnt = 7; (flash | torch) === 1'b1 && cnt < 20000; cnt++)
                @(posedge clk_i);
            chk("timeout_len", 32'(cnt > (n + 1) * STEP - lstbg_pkg::TICK_CYCLES
                && cnt < (n + 1) * STEP + 16), 32'h1);
            repeat (50) @(posedge clk_i);
            chk("flash_latched", 32'(flash | torch), 32'h0);
            chk("irq_timeout", 32'(irq), 32'h1);
            rdchk(lstbg_pkg::ADDR_CONTROL, 32'h10, "ctl_tripped");
            bus(1'b1, lstbg_pkg::ADDR_IRQ_STAT, 32'h1);
            repeat (3) @(posedge clk_i);
            chk("irq_clear", 32'(irq), 32'h0);
        end
        $display("test timer done");
        // timer off, then current equal to the arming level
        for (int k = 0; k < 2; k++)
        begin
            bus(1'b1, lstbg_pkg::ADDR_ARMING, k ? 32'h5 : 32'h0);
            level <= k ? 11'h12c : 11'h096;
            bus(1'b1, lstbg_pkg::ADDR_CONTROL, k ? 32'h2 : 32'h1);
            repeat (3 * STEP) @(posedge clk_i);
            chk("no_trip", 32'(flash | torch), 32'h1);
            rdchk(lstbg_pkg::ADDR_CONTROL, k ? 32'h2 : 32'h1, "not_armed");
        end
        $display("test arming done");
        // battery floor: just under and at the threshold of codes 0, 1, 5 and 9
        bus(1'b1, lstbg_pkg::ADDR_IRQ_MASK, 32'h2);
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b1, lstbg_pkg::ADDR_FLOOR, 32'(codes[i]));
            supply <= 13'(lstbg_pkg::FLOOR_BASE_MV + lstbg_pkg::FLOOR_STEP_MV * codes[i] - 1);
            repeat (4) @(posedge clk_i);
            chk("low_bat", 32'(lowbat), 32'(codes[i] != 4'h0));
            chk("drive_off", 32'(torch), 32'(codes[i] == 4'h0));
            chk("irq_lowbat", 32'(irq), 32'(codes[i] != 4'h0));
            rdchk(lstbg_pkg::ADDR_CONTROL, codes[i] != 4'h0 ? 32'ha : 32'h2, "ctl_lowbat");
            bus(1'b1, lstbg_pkg::ADDR_IRQ_STAT, 32'h2);
            supply <= supply + 13'h1;
            repeat (4) @(posedge clk_i);
            chk("floor_edge", 32'(lowbat), 32'h0);
            chk("irq_lowbat_clr", 32'(irq), 32'h0);
        end
        $display("test battery done");
        end_sim();
    end
endmodule : led_safety_timer_battery_guard_tb

// ---- dv/lstbg_assertions.sv ----
// checker: port properties of the led safety guard
`timescale 1ns/1ps
module lstbg_assertions
#(
    parameter int STEP_TICKS = 4
)
(
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire logic [3:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic [12:0] supply_mv_i,
    input wire logic [10:0] led_ma_i,
    input wire logic        flash_drive_o,
    input wire logic        torch_drive_o,
    input wire logic        low_battery_o,
    input wire logic        irq_o
);
    // ************************************************************
    // shadow codes, followed from accepted writes
    // ************************************************************
    logic [3:0] floor_q;   // floor code as the host left it
    logic [1:0] mask_q;    // event mask
    logic       wr_acc;    // write accepted this edge
    logic       ctl_acc;   // control write accepted
    logic       lb_cond;   // supply below an enabled floor
    assign wr_acc  = avs_write_i && !avs_waitrequest_o;
    assign ctl_acc = wr_acc && avs_address_i == lstbg_pkg::ADDR_CONTROL;
    assign lb_cond = floor_q != lstbg_pkg::FLOOR_OFF && int'(supply_mv_i) <
        lstbg_pkg::FLOOR_BASE_MV + lstbg_pkg::FLOOR_STEP_MV * int'(floor_q);

    // shadow registers update at the same edge as the bank
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            floor_q <= lstbg_pkg::FLOOR_RST;
            mask_q  <= 2'h0;
        end
        else if (wr_acc && avs_address_i == lstbg_pkg::ADDR_FLOOR)
            floor_q <= avs_writedata_i[3:0];
        else if (wr_acc && avs_address_i == lstbg_pkg::ADDR_IRQ_MASK)
            mask_q <= avs_writedata_i[1:0];
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // ************************************************************
    // properties
    // ************************************************************
    AST_RST_OUT: assert property ($past(reset_i) |-> avs_waitrequest_o && !flash_drive_o
        && !torch_drive_o && !low_battery_o && !irq_o && avs_readdata_o == 32'h0)
        else $error("outputs not idle after reset");
    AST_REQ_ANSWER: assert property ((avs_read_i || avs_write_i) |-> ##[0:2] !avs_waitrequest_o)
        else $error("request not answered in time");
    AST_WAIT_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    AST_IDLE_WAIT: assert property (!avs_read_i && !avs_write_i |=> avs_waitrequest_o)
        else $error("waitrequest low without a request");
    AST_LB_MATCH: assert property (!$past(reset_i) |-> low_battery_o == $past(lb_cond))
        else $error("low battery flag disagrees with floor");
    AST_LB_DRIVE_OFF: assert property ($past(lb_cond) |-> !flash_drive_o && !torch_drive_o)
        else $error("drive on during low battery");
    AST_IRQ_MASKED: assert property ($past(mask_q) == 2'h0 |-> !irq_o)
        else $error("interrupt while fully masked");
    AST_DRIVE_RISE: assert property ($rose(flash_drive_o) |-> $past(ctl_acc) || $past(ctl_acc, 2)
        || $past(ctl_acc, 3) || $past(low_battery_o) || $past(low_battery_o, 2))
        else $error("drive rose without a host enable");

    // main scenarios
    COV_TRIP: cover property ($fell(flash_drive_o) && !low_battery_o);
    COV_LOWBAT: cover property ($rose(low_battery_o));
    COV_IRQ: cover property ($rose(irq_o));
endmodule : lstbg_assertions

bind lstbg_top lstbg_assertions #(.STEP_TICKS(STEP_TICKS)) u_chk (.clk_i(clk_i),
    .reset_i(reset_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .supply_mv_i(supply_mv_i), .led_ma_i(led_ma_i), .flash_drive_o(flash_drive_o),
    .torch_drive_o(torch_drive_o), .low_battery_o(low_battery_o), .irq_o(irq_o));

// ---- dv/lstbg_led_model.sv ----
// partner: led whose current follows the drive enables
`timescale 1ns/1ps
module lstbg_led_model
(
    input  wire logic        flash_i,
    input  wire logic        torch_i,
    input  wire logic [10:0] level_i,
    output logic [10:0]      led_ma_o
);
    // dark led draws nothing, so an unlit string never arms the timer
    assign led_ma_o = (flash_i || torch_i) ? level_i : 11'h0;
endmodule : lstbg_led_model

// ---- hdl/lstbg_pkg.sv ----
// package: register map, reset values and timing constants for the led safety guard
package lstbg_pkg;

    // ************************************************************
    // register map (word offsets 0 to 5, one per register)
    // ************************************************************
    localparam logic [3:0] ADDR_TIMEOUT   = 4'h0;   // timeout length code
    localparam logic [3:0] ADDR_FLOOR     = 4'h1;   // battery floor code
    localparam logic [3:0] ADDR_ARMING    = 4'h2;   // arming current code
    localparam logic [3:0] ADDR_CONTROL   = 4'h3;   // drive enable and status
    localparam logic [3:0] ADDR_IRQ_STAT  = 4'h4;   // sticky event bits
    localparam logic [3:0] ADDR_IRQ_MASK  = 4'h5;   // event mask

    // ************************************************************
    // field widths and reset values
    // ************************************************************
    localparam int          TIMEOUT_W      = 3;
    localparam int          FLOOR_W        = 4;
    localparam int          ARMING_W       = 3;
    localparam logic [2:0]  TIMEOUT_RST    = 3'h7;  // longest time-out
    localparam logic [3:0]  FLOOR_RST      = 4'h1;  // 3.0 v floor
    localparam logic [2:0]  ARMING_RST     = 3'h4;  // 250 ma arming
    localparam logic [3:0]  FLOOR_OFF      = 4'h0;  // low battery check off
    localparam logic [2:0]  ARMING_OFF     = 3'h0;  // safety timer off

    // control register fields
    localparam int          CTL_FLASH_BIT  = 0;
    localparam int          CTL_TORCH_BIT  = 1;
    localparam int          CTL_ARMED_BIT  = 2;     // read only
    localparam int          CTL_LOWBAT_BIT = 3;     // read only
    localparam int          CTL_TRIP_BIT   = 4;     // read only

    // interrupt bits
    localparam int          IRQ_W          = 2;
    localparam int          IRQ_TIMEOUT    = 0;
    localparam int          IRQ_LOWBAT     = 1;

    // ************************************************************
    // timing: one time-out step, in microseconds, and tick divider
    // ************************************************************
    localparam int          CLK_MHZ        = 200;
    localparam int          STEP_US        = 156250;          // 156.25 ms
    localparam int          TICK_US        = 1;               // divider tick period
    localparam int          TICK_CYCLES    = TICK_US * CLK_MHZ;
    localparam int          STEP_TICKS     = STEP_US / TICK_US;

    // analog scale for sense codes: millivolts and milliamps
    localparam int          FLOOR_BASE_MV  = 2900;            // code 1 gives 3000
    localparam int          FLOOR_STEP_MV  = 100;
    localparam int          ARM_BASE_MA    = 50;              // code 1 gives 100
    localparam int          ARM_STEP_MA    = 50;

endpackage : lstbg_pkg

// ---- hdl/lstbg_tick.sv ----
// tick divider: one-cycle enable pulse every period cycles
`timescale 1ns/1ps
module lstbg_tick
#(
    parameter int PERIOD = 200
)
(
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic clear_i,
    output logic      tick_o
);
    logic [15:0] cnt_q;   // cycles since last tick

    // ************************************************************
    // free counter, restarted on clear so a new run starts aligned
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (reset_i || clear_i)
        begin
            cnt_q  <= 16'h0000;
            tick_o <= 1'b0;
        end
        else if (cnt_q == 16'(PERIOD - 1))
        begin
            cnt_q  <= 16'h0000;
            tick_o <= 1'b1;
        end
        else
        begin
            cnt_q  <= cnt_q + 16'h0001;
            tick_o <= 1'b0;
        end
    end
endmodule : lstbg_tick

// ---- hdl/lstbg_top.sv ----
// top: register bank, safety timer and battery guard for the led driver
// Functional notes
// - timer limits flash/torch when current above threshold
// - time-out is (code+1) times 156.25 ms
// - timeout length code resets to 7
// - low supply sets flag, disables driver
// - floor code 0 off, 1-9 3.0-3.8V
// - battery floor code resets to 1
// - timer starts only above arming current
// - arming code 0 off, 1-5 100-300 mA
// - arming current code resets to 4
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module lstbg_top
#(
    parameter int STEP_TICKS = lstbg_pkg::STEP_TICKS   // 1 us ticks per 156.25 ms step
)
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    // analog measurements, synchronous
    input  wire logic [12:0] supply_mv_i,
    input  wire logic [10:0] led_ma_i,
    // drive and flag outputs
    output logic             flash_drive_o,
    output logic             torch_drive_o,
    output logic             low_battery_o,
    output logic             irq_o
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [2:0]  timeout_length_code_q;   // time-out step count minus one
    logic [3:0]  battery_floor_code_q;    // low battery floor select
    logic [2:0]  arming_current_code_q;   // safety timer arming select
    logic        flash_en_q;              // host flash enable
    logic        torch_en_q;              // host torch enable
    logic        tripped_q;               // time-out latched drive off
    logic        low_bat_q;               // internal low battery flag
    logic        armed_q;                 // led current above arming level
    logic [1:0]  irq_stat_q;              // sticky events
    logic [1:0]  irq_mask_q;              // event enables
    logic        ack_q;                   // one-cycle answer slot
    logic [20:0] step_cnt_q;              // ticks within current step
    logic [3:0]  steps_q;                 // whole steps elapsed
    logic        timeout_ev;              // time-out reached this cycle
    logic        lowbat_rise;             // low battery flag rising
    logic        tick;                    // 1 us enable
    logic        wr_ok;                   // write taken this cycle
    logic        rd_load;                 // read data captured this cycle
    logic        req_first;               // request seen, answer not yet given
    logic        low_now;                 // supply below floor
    logic        arm_now;                 // current above arming level

    // ************************************************************
    // code decode helpers
    // ************************************************************
    // floor in millivolts; codes above 9 are undefined by contract
    function automatic logic [12:0] floor_mv(input logic [3:0] code);
        floor_mv = 13'(lstbg_pkg::FLOOR_BASE_MV + lstbg_pkg::FLOOR_STEP_MV * int'(code));
    endfunction : floor_mv

    // arming current in milliamps
    function automatic logic [10:0] arm_ma(input logic [2:0] code);
        arm_ma = 11'(lstbg_pkg::ARM_BASE_MA + lstbg_pkg::ARM_STEP_MA * int'(code));
    endfunction : arm_ma

    // ************************************************************
    // bus handshake: every access waits exactly one cycle
    // ************************************************************
    // the master holds its request until it sees waitrequest low, so
    // the second cycle of a request is the one in which it is taken
    assign req_first = (avs_read_i || avs_write_i) && !ack_q;
    assign wr_ok     = avs_write_i && ack_q;
    assign rd_load   = avs_read_i && !ack_q;   // data ready one cycle ahead

    // answer slot toggles so waitrequest drops on the second cycle
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            ack_q <= 1'b0;
        else
            ack_q <= req_first;
    end

    // waitrequest high except in the answer cycle; registered
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            avs_waitrequest_o <= 1'b1;
        else
            avs_waitrequest_o <= !req_first;
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    // writes land at the edge that samples waitrequest low
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            timeout_length_code_q <= lstbg_pkg::TIMEOUT_RST;
            battery_floor_code_q  <= lstbg_pkg::FLOOR_RST;
            arming_current_code_q <= lstbg_pkg::ARMING_RST;
            irq_mask_q            <= 2'h0;
        end
        else if (wr_ok)
        begin
            unique case (avs_address_i)
                lstbg_pkg::ADDR_TIMEOUT:
                    timeout_length_code_q <= avs_writedata_i[2:0];
                lstbg_pkg::ADDR_FLOOR:
                    battery_floor_code_q  <= avs_writedata_i[3:0];
                lstbg_pkg::ADDR_ARMING:
                    arming_current_code_q <= avs_writedata_i[2:0];
                lstbg_pkg::ADDR_IRQ_MASK:
                    irq_mask_q            <= avs_writedata_i[1:0];
                default:
                    ;   // other offsets handled elsewhere or ignored
            endcase
        end
    end

    // ************************************************************
    // host enables; a time-out trip clears them and holds them off
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            flash_en_q <= 1'b0;
            torch_en_q <= 1'b0;
            tripped_q  <= 1'b0;
        end
        else if (timeout_ev)
        begin
            // trip wins over a control write in the same cycle; the host
            // must write again once it has seen the trip bit
            flash_en_q <= 1'b0;
            torch_en_q <= 1'b0;
            tripped_q  <= 1'b1;
        end
        else if (wr_ok && avs_address_i == lstbg_pkg::ADDR_CONTROL)
        begin
            // a fresh enable write is the only way out of a trip
            flash_en_q <= avs_writedata_i[lstbg_pkg::CTL_FLASH_BIT];
            torch_en_q <= avs_writedata_i[lstbg_pkg::CTL_TORCH_BIT];
            tripped_q  <= 1'b0;
        end
    end

    // ************************************************************
    // analog comparisons, registered
    // ************************************************************
    // strict compares: at the floor is not low, at the level not armed
    assign low_now = (battery_floor_code_q != lstbg_pkg::FLOOR_OFF) &&
                     (supply_mv_i < floor_mv(battery_floor_code_q));
    assign arm_now = (arming_current_code_q != lstbg_pkg::ARMING_OFF) &&
                     (led_ma_i > arm_ma(arming_current_code_q));

    // flag follows the comparison each cycle; no hysteresis modelled
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            low_bat_q <= 1'b0;
            armed_q   <= 1'b0;
        end
        else
        begin
            low_bat_q <= low_now;
            armed_q   <= arm_now && (flash_en_q || torch_en_q);
        end
    end

    // rising edge only, so a supply held low raises a single event
    assign lowbat_rise = low_now && !low_bat_q;

    // ************************************************************
    // safety timer: counts 1 us ticks while armed
    // ************************************************************
    lstbg_tick #(
        .PERIOD (lstbg_pkg::TICK_CYCLES)
    ) u_tick (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .clear_i (!armed_q),
        .tick_o  (tick)
    );

    // time-out when steps reach code+1
    assign timeout_ev = armed_q && (steps_q == {1'b0, timeout_length_code_q} + 4'h1);

    // dropping below the arming level restarts the timer from zero
    always_ff @(posedge clk_i)
    begin
        if (reset_i || !armed_q || timeout_ev)
        begin
            step_cnt_q <= 21'h000000;
            steps_q    <= 4'h0;
        end
        else if (tick)
        begin
            if (step_cnt_q == 21'(STEP_TICKS - 1))
            begin
                step_cnt_q <= 21'h000000;
                steps_q    <= steps_q + 4'h1;
            end
            else
                step_cnt_q <= step_cnt_q + 21'h000001;
        end
    end

    // ************************************************************
    // interrupts: set wins over write-one-to-clear
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            irq_stat_q <= 2'h0;
        else
        begin
            // one bit per event; a clear touches only the bits written one
            for (int i = 0; i < lstbg_pkg::IRQ_W; i++)
            begin
                if ((i == lstbg_pkg::IRQ_TIMEOUT && timeout_ev) ||
                    (i == lstbg_pkg::IRQ_LOWBAT && lowbat_rise))
                    irq_stat_q[i] <= 1'b1;
                else if (wr_ok && avs_address_i == lstbg_pkg::ADDR_IRQ_STAT &&
                         avs_writedata_i[i])
                    irq_stat_q[i] <= 1'b0;
            end
        end
    end

    // irq registered from status and mask
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(irq_stat_q & irq_mask_q);
    end

    // ************************************************************
    // outputs: driver off under low battery or trip
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            flash_drive_o <= 1'b0;
            torch_drive_o <= 1'b0;
            low_battery_o <= 1'b0;
        end
        else
        begin
            // the trip cycle itself already drops the drive
            flash_drive_o <= flash_en_q && !low_now && !timeout_ev;
            torch_drive_o <= torch_en_q && !low_now && !timeout_ev;
            low_battery_o <= low_now;
        end
    end

    // ************************************************************
    // read data, zero for unmapped offsets
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            avs_readdata_o <= 32'h00000000;
        // captured a cycle early so the word stands at the taking edge
        else if (rd_load)
        begin
            unique case (avs_address_i)
                lstbg_pkg::ADDR_TIMEOUT:  avs_readdata_o <= {29'h0, timeout_length_code_q};
                lstbg_pkg::ADDR_FLOOR:    avs_readdata_o <= {28'h0, battery_floor_code_q};
                lstbg_pkg::ADDR_ARMING:   avs_readdata_o <= {29'h0, arming_current_code_q};
                lstbg_pkg::ADDR_CONTROL:
                begin
                    // status bits placed by the package field positions
                    avs_readdata_o                            <= 32'h00000000;
                    avs_readdata_o[lstbg_pkg::CTL_FLASH_BIT]  <= flash_en_q;
                    avs_readdata_o[lstbg_pkg::CTL_TORCH_BIT]  <= torch_en_q;
                    avs_readdata_o[lstbg_pkg::CTL_ARMED_BIT]  <= armed_q;
                    avs_readdata_o[lstbg_pkg::CTL_LOWBAT_BIT] <= low_bat_q;
                    avs_readdata_o[lstbg_pkg::CTL_TRIP_BIT]   <= tripped_q;
                end
                lstbg_pkg::ADDR_IRQ_STAT: avs_readdata_o <= {30'h0, irq_stat_q};
                lstbg_pkg::ADDR_IRQ_MASK: avs_readdata_o <= {30'h0, irq_mask_q};
                default:                  avs_readdata_o <= 32'h00000000;
            endcase
        end
    end
endmodule : lstbg_top
